// ### tgt_pkg.sv
// Constants, register map and state type of the I2C target access block.
// Assumes a 32-bit APB bus with byte addresses, one aligned word per register.
package tgt_pkg;

  // ==========================================================================
  // Register map
  localparam logic [31:0] CFG_ADDR   = 32'h0001d12c;
  localparam logic [31:0] STAT_ADDR  = 32'h0001d130;
  localparam logic [31:0] MASK_ADDR  = 32'h0001d134;
  localparam logic [31:0] ALERT_ADDR = 32'h0001d138;

  // ==========================================================================
  // Configuration fields, reset value and writable bits
  localparam logic [31:0] CFG_RESET = 32'hd0000030;
  localparam logic [31:0] CFG_MASK  = 32'hf100007f;
  localparam int          RD_EN     = 31;
  localparam int          WR_EN     = 30;
  localparam int          ALERT_EN  = 29;
  localparam int          TGT_EN    = 28;
  localparam int          UNLOCK    = 24;
  localparam int          ADDR_HI   = 6;
  localparam int          STRAP_HI  = 1;

  // ==========================================================================
  // Interrupt status bits
  localparam int IRQ_W       = 4;
  localparam int IRQ_WRITE   = 0;
  localparam int IRQ_READ    = 1;
  localparam int IRQ_ALERT   = 2;
  localparam int IRQ_REFUSED = 3;

  // ==========================================================================
  // Bus constants and counts
  localparam logic [6:0] ALERT_RSP  = 7'h0c;
  localparam logic [6:0] GEN_CALL   = 7'h00;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [1:0] LAST_BYTE  = 2'h3;
  localparam logic [1:0] STRAP_LOAD = 2'h2;
  localparam logic [3:0] SYNC_INIT  = 4'hc;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_ack_wait, st_ack_drive,
    st_wr_byte, st_rd_byte, st_mack, st_skip
  } state_t;

endpackage

// ### link_ev_if.sv
// Bus events found on the sampled SCL and SDA lines.
// Assumes both ends run on the same clock; events are one-cycle pulses.
interface link_ev_if;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic sda;
  modport src (output start, stop, rise, fall, sda);
  modport dst (input start, stop, rise, fall, sda);
endinterface

// ### sync_pair.sv
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes the inputs are levels that stay stable for several clocks.
module sync_pair #(
  parameter int           W    = 4,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ### bus_events.sv
// Start, stop and clock-edge detection on synchronised SCL and SDA.
// Assumes both inputs already passed a synchroniser.
module bus_events (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic scl_s,
  input  wire logic sda_s,
  link_ev_if.src    ev
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // SDA moving while SCL stays high marks start or stop
  assign ev.start = scl_q & scl_s & sda_q & ~sda_s;
  assign ev.stop  = scl_q & scl_s & ~sda_q & sda_s;
  assign ev.rise  = ~scl_q & scl_s;
  assign ev.fall  = scl_q & ~scl_s;
  assign ev.sda   = sda_s;

endmodule

// ### i2c_target_access_config.sv
// I2C target access gating with its configuration register on APB.
// Assumes an external controller on SCL/SDA and an internal register port
// that answers a read request with int_rd_valid before the data byte starts.

module i2c_target_access_config (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [1:0]  addr_strap,
  input  wire logic        alert_event,
  input  wire logic [31:0] wr_address,
  input  wire logic [31:0] rd_address,
  output logic             int_wr_req,
  output logic      [31:0] int_wr_addr,
  output logic      [31:0] int_wr_data,
  output logic             int_rd_req,
  output logic      [31:0] int_rd_addr,
  input  wire logic [31:0] int_rd_data,
  input  wire logic        int_rd_valid,
  output logic             irq
);

  // ==========================================================================
  // Pin synchronisers and bus events
  logic [3:0] pins_s;
  link_ev_if  ev ();

  sync_pair #(.W(4), .INIT(tgt_pkg::SYNC_INIT)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .d     ({scl, sda_i, addr_strap}),
    .q     (pins_s)
  );

  bus_events u_events (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .scl_s (pins_s[3]),
    .sda_s (pins_s[2]),
    .ev    (ev)
  );

  // ==========================================================================
  // Declarations
  tgt_pkg::state_t state;
  logic [31:0] cfg;
  logic [1:0]  strap_cnt;
  logic        snap_rd;
  logic        snap_wr;
  logic        snap_alert;
  logic        snap_en;
  logic [6:0]  snap_addr;
  logic [2:0]  bit_cnt;
  logic [1:0]  byte_idx;
  logic [7:0]  shift;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic        txn_read;
  logic        txn_alert;
  logic        ack_pending;
  logic        alert_pend;
  logic [tgt_pkg::IRQ_W-1:0] irq_stat;
  logic [tgt_pkg::IRQ_W-1:0] irq_mask;
  logic [tgt_pkg::IRQ_W-1:0] irq_ev;
  logic [7:0]  cur_byte;
  logic [31:0] wr_full;
  logic [6:0]  rx_addr;
  logic        setup;
  logic        wr;
  logic        strap_load;
  logic        addr_last;
  logic        alert_hit;
  logic        alert_ack;
  logic        normal_match;
  logic        ack_addr;
  logic        rd_go;
  logic        rd_refused;
  logic        wr_last;
  logic        wr_go;
  logic        wr_refused;
  logic        alert_done;
  logic        alert_sw_set;

  // ==========================================================================
  // APB slave
  assign setup        = psel & ~penable;
  assign pready       = ce;
  assign wr           = ce & psel & penable & pwrite;
  assign alert_sw_set = wr && paddr == tgt_pkg::ALERT_ADDR && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      pslverr <= 1'b0;
      case (paddr)
        tgt_pkg::CFG_ADDR:   prdata <= cfg;
        tgt_pkg::STAT_ADDR:  prdata <= 32'(irq_stat);
        tgt_pkg::MASK_ADDR:  prdata <= 32'(irq_mask);
        tgt_pkg::ALERT_ADDR: prdata <= 32'(alert_pend);
        default: begin
          prdata  <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Configuration register and strap capture
  assign strap_load = ce && strap_cnt == tgt_pkg::STRAP_LOAD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt <= 2'h0;
    end else if (ce && strap_cnt != tgt_pkg::LAST_BYTE) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= tgt_pkg::CFG_RESET;
    end else if (ce) begin
      if (strap_load) begin
        cfg[tgt_pkg::STRAP_HI:0] <= pins_s[1:0];
      end
      if (wr && paddr == tgt_pkg::CFG_ADDR) begin
        cfg <= pwdata & tgt_pkg::CFG_MASK;
        if (!pwdata[tgt_pkg::UNLOCK]) begin
          cfg[tgt_pkg::STRAP_HI:0] <= cfg[tgt_pkg::STRAP_HI:0];
        end
      end
    end
  end

  // Settings are frozen at each start condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_rd    <= 1'b0;
      snap_wr    <= 1'b0;
      snap_alert <= 1'b0;
      snap_en    <= 1'b0;
      snap_addr  <= 7'h0;
    end else if (ce && ev.start) begin
      snap_rd    <= cfg[tgt_pkg::RD_EN];
      snap_wr    <= cfg[tgt_pkg::WR_EN];
      snap_alert <= cfg[tgt_pkg::ALERT_EN];
      snap_en    <= cfg[tgt_pkg::TGT_EN];
      snap_addr  <= cfg[tgt_pkg::ADDR_HI:0];
    end
  end

  // ==========================================================================
  // Address decision
  assign rx_addr   = shift[6:0];
  assign addr_last = ce && ev.rise && state == tgt_pkg::st_addr &&
                     bit_cnt == tgt_pkg::LAST_BIT;
  assign alert_hit = snap_alert && rx_addr == tgt_pkg::ALERT_RSP;
  assign alert_ack = alert_hit && ev.sda && alert_pend;
  // Alert path wins over own address; zero address never matches
  assign normal_match = snap_en && !alert_hit && rx_addr == snap_addr &&
                        rx_addr != tgt_pkg::GEN_CALL;
  assign ack_addr   = alert_ack || normal_match;
  assign rd_go      = addr_last && normal_match && ev.sda &&
                      snap_en && snap_rd;
  assign rd_refused = addr_last && normal_match && ev.sda &&
                      !(snap_en && snap_rd);
  assign wr_full    = {wr_word[23:0], shift[6:0], ev.sda};
  assign wr_last    = ce && ev.rise && state == tgt_pkg::st_wr_byte &&
                      bit_cnt == tgt_pkg::LAST_BIT &&
                      byte_idx == tgt_pkg::LAST_BYTE;
  assign wr_go      = wr_last && snap_en && snap_wr;
  assign wr_refused = wr_last && !(snap_en && snap_wr);
  assign alert_done = ce && ev.fall && state == tgt_pkg::st_rd_byte &&
                      bit_cnt == 3'h0 && txn_alert && byte_idx == 2'h0;

  always_comb begin
    cur_byte = 8'hff;
    if (txn_alert) begin
      if (byte_idx == 2'h0) begin
        cur_byte = {snap_addr, 1'b0};
      end
    end else begin
      case (byte_idx)
        2'h0:    cur_byte = rd_word[31:24];
        2'h1:    cur_byte = rd_word[23:16];
        2'h2:    cur_byte = rd_word[15:8];
        default: cur_byte = rd_word[7:0];
      endcase
    end
  end

  // ==========================================================================
  // Byte engine
  assign sda_o = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= tgt_pkg::st_idle;
      bit_cnt     <= 3'h0;
      byte_idx    <= 2'h0;
      shift       <= 8'h0;
      wr_word     <= 32'h0;
      txn_read    <= 1'b0;
      txn_alert   <= 1'b0;
      ack_pending <= 1'b0;
      sda_oe      <= 1'b0;
    end else if (ce) begin
      if (ev.start) begin
        state   <= tgt_pkg::st_addr;
        bit_cnt <= 3'h0;
        sda_oe  <= 1'b0;
      end else if (ev.stop) begin
        state  <= tgt_pkg::st_idle;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          tgt_pkg::st_addr: if (ev.rise) begin
            shift   <= {shift[6:0], ev.sda};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == tgt_pkg::LAST_BIT) begin
              txn_read    <= ev.sda;
              txn_alert   <= alert_ack;
              ack_pending <= ack_addr;
              byte_idx    <= 2'h0;
              state       <= tgt_pkg::st_ack_wait;
            end
          end
          tgt_pkg::st_ack_wait: if (ev.fall) begin
            sda_oe <= ack_pending;
            state  <= ack_pending ? tgt_pkg::st_ack_drive : tgt_pkg::st_skip;
          end
          tgt_pkg::st_ack_drive: if (ev.fall) begin
            bit_cnt <= 3'h0;
            if (txn_read) begin
              sda_oe <= ~cur_byte[7];
              state  <= tgt_pkg::st_rd_byte;
            end else begin
              sda_oe <= 1'b0;
              state  <= tgt_pkg::st_wr_byte;
            end
          end
          tgt_pkg::st_wr_byte: if (ev.rise) begin
            shift   <= {shift[6:0], ev.sda};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == tgt_pkg::LAST_BIT) begin
              wr_word     <= wr_full;
              byte_idx    <= byte_idx + 2'h1;
              ack_pending <= 1'b1;
              state       <= tgt_pkg::st_ack_wait;
            end
          end
          tgt_pkg::st_rd_byte: begin
            if (ev.rise) begin
              bit_cnt <= bit_cnt + 3'h1;
            end else if (ev.fall) begin
              if (bit_cnt == 3'h0) begin
                sda_oe <= 1'b0;
                state  <= tgt_pkg::st_mack;
              end else begin
                sda_oe <= ~cur_byte[tgt_pkg::LAST_BIT - bit_cnt];
              end
            end
          end
          tgt_pkg::st_mack: if (ev.rise) begin
            if (ev.sda) begin
              state <= tgt_pkg::st_skip;
            end else begin
              byte_idx <= byte_idx + 2'h1;
              state    <= tgt_pkg::st_ack_drive;
            end
          end
          tgt_pkg::st_idle, tgt_pkg::st_skip: state <= state;
          default: state <= tgt_pkg::st_idle;
        endcase
      end
    end
  end

  // ==========================================================================
  // Internal register port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_rd_req  <= 1'b0;
      int_rd_addr <= 32'h0;
      int_wr_req  <= 1'b0;
      int_wr_addr <= 32'h0;
      int_wr_data <= 32'h0;
    end else if (ce) begin
      int_rd_req <= rd_go;
      int_wr_req <= wr_go;
      if (rd_go) begin
        int_rd_addr <= rd_address;
      end
      if (wr_go) begin
        int_wr_addr <= wr_address;
        int_wr_data <= wr_full;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_word <= 32'h0;
    end else if (ce) begin
      if (rd_refused) begin
        rd_word <= 32'h0;
      end else if (int_rd_valid) begin
        rd_word <= int_rd_data;
      end
    end
  end

  // ==========================================================================
  // Alert flag and interrupts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_pend <= 1'b0;
    end else if (ce) begin
      if (alert_event || alert_sw_set) begin
        alert_pend <= 1'b1;
      end else if (alert_done) begin
        alert_pend <= 1'b0;
      end
    end
  end

  assign irq_ev = {rd_refused | wr_refused, alert_done, rd_go, wr_go};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else if (ce) begin
      if (wr && paddr == tgt_pkg::STAT_ADDR) begin
        irq_stat <= (irq_stat & ~pwdata[tgt_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat <= irq_stat | irq_ev;
      end
      if (wr && paddr == tgt_pkg::MASK_ADDR) begin
        irq_mask <= pwdata[tgt_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence addr_seen;
    addr_last;
  endsequence

  sequence alert_sent;
    alert_done ##0 !alert_event ##0 !alert_sw_set;
  endsequence

  read_launch_a: assert property (
    addr_seen ##0 (normal_match && ev.sda && snap_en && snap_rd)
    |=> int_rd_req && int_rd_addr == $past(rd_address))
    else $error("permitted window read did not launch");
  read_block_a: assert property (
    int_rd_req |-> $past(snap_rd) && $past(normal_match))
    else $error("internal read without permit");
  write_launch_a: assert property (
    wr_go |=> int_wr_req && int_wr_data == $past(wr_full))
    else $error("permitted window write did not launch");
  write_block_a: assert property (
    int_wr_req |-> $past(snap_wr) && !$past(wr_refused))
    else $error("internal write without permit");
  enable_gate_a: assert property (
    (int_wr_req || int_rd_req) |-> $past(snap_en))
    else $error("internal access with target disabled");
  alert_ack_a: assert property (
    addr_seen ##0 (snap_alert && rx_addr == tgt_pkg::ALERT_RSP && ev.sda && alert_pend)
    |=> ack_pending && txn_alert)
    else $error("alert read not acknowledged");
  alert_off_a: assert property (
    addr_seen ##0 (!snap_alert && rx_addr == tgt_pkg::ALERT_RSP &&
                   snap_addr != tgt_pkg::ALERT_RSP) |=> !ack_pending)
    else $error("alert address answered while disabled");
  alert_clear_a: assert property (
    alert_sent |=> !alert_pend ##1 !sda_oe)
    else $error("alert flag not cleared after answer");
  alert_as_own_a: assert property (
    addr_seen ##0 (!snap_alert && snap_en && snap_addr == tgt_pkg::ALERT_RSP &&
                   rx_addr == tgt_pkg::ALERT_RSP) |=> ack_pending && !txn_alert)
    else $error("alert address not usable as own address");
  alert_first_a: assert property (
    addr_seen ##0 alert_hit |=> !int_rd_req && !int_wr_req)
    else $error("normal access on alert address");
  nack_drop_a: assert property (
    (ce && ev.fall && state == tgt_pkg::st_ack_wait && !ack_pending && !ev.start)
    |=> !sda_oe && state == tgt_pkg::st_skip)
    else $error("unmatched address was acknowledged");
  disabled_a: assert property (
    addr_seen ##0 (!snap_en && !alert_ack) |=> !ack_pending)
    else $error("disabled target acknowledged");
  addr_lock_a: assert property (
    (wr && paddr == tgt_pkg::CFG_ADDR && !pwdata[tgt_pkg::UNLOCK] && !strap_load)
    |=> cfg[tgt_pkg::STRAP_HI:0] == $past(cfg[tgt_pkg::STRAP_HI:0]))
    else $error("locked address bits changed");
  gen_call_a: assert property (
    addr_seen ##0 (rx_addr == tgt_pkg::GEN_CALL) |=> !ack_pending)
    else $error("general call acknowledged");
  snap_hold_a: assert property (
    !(ce && ev.start) |=> $stable(snap_en) && $stable(snap_addr) && $stable(snap_rd))
    else $error("settings changed inside a transaction");

endmodule

// ### i2c_host_model.sv
// Behavioural I2C bus controller for the target access bench.
// Assumes SDA is an open-drain wire with a pull-up, resolved by the bench.
module i2c_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 10ps;
  // ==========================================================================
  // Bus phases, 125 ns a bit; SCL stands high between frames
  localparam realtime Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // Sends a byte MSB first; ack is high when the target pulled SDA low
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
      #Q;
    end
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q ack = ~sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic get(input logic nack, output logic [7:0] b);
    sda_low = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #Q scl = 1'b1;
      #Q b = {b[6:0], sda};
      #Q scl = 1'b0;
      #Q;
    end
    sda_low = ~nack;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
    #Q;
  endtask
endmodule

// ### tb.sv
// Self-checking bench of the I2C target access block.
// Assumes the controller model drives the link and APB runs at zero wait states.
`define CHK(n, e, a) \
  begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected %s: expected %h seen %h", n, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 10ps;
  // ==========================================================================
  // Signals, design and far-side model
  localparam logic [6:0]  SA = 7'h32;
  localparam logic [31:0] WA = 32'h00000a40;
  localparam logic [31:0] RA = 32'h00000b84;
  localparam logic [31:0] RD = 32'ha5c31e87;
  logic        pclk, pready, pslverr, scl, sda, sda_o, sda_oe, host_low, irq, err, a1;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        alert_event = 1'b0, int_rd_valid = 1'b0, int_wr_req, int_rd_req;
  logic [31:0] paddr = '0, pwdata = '0, prdata, int_wr_addr, int_wr_data, int_rd_addr;
  logic [31:0] wr_a, wr_d, rd_a, v;
  logic [7:0]  b;
  int          bad_count = 0, checks_done = 0, wr_n = 0, rd_n = 0, n, m, cyc = 0;
  i2c_target_access_config dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap(2'h2), .alert_event(alert_event), .wr_address(WA),
    .rd_address(RA), .int_wr_req(int_wr_req), .int_wr_addr(int_wr_addr),
    .int_wr_data(int_wr_data), .int_rd_req(int_rd_req), .int_rd_addr(int_rd_addr),
    .int_rd_data(RD), .int_rd_valid(int_rd_valid), .irq(irq));
  i2c_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));
  assign sda = ~host_low & (~sda_oe | sda_o);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Internal register port answers a read one clock after the request
  always @(posedge pclk) begin
    int_rd_valid <= int_rd_req;
    if (int_wr_req === 1'b1) begin
      wr_n++;
      wr_a = int_wr_addr;
      wr_d = int_wr_data;
    end
    if (int_rd_req === 1'b1) begin
      rd_n++;
      rd_a = int_rd_addr;
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("unexpected timeout");
      test_done();
    end
  end
  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, v);
  endtask
  task automatic rdc(input string s, input logic [31:0] a, e);
    apb(1'b0, a, '0, v);
    `CHK(s, e, v);
  endtask
  task automatic adr(input logic [7:0] x);
    host.start();
    host.put(x, a1);
  endtask
  task automatic wr4(input logic [31:0] d);
    for (int i = 3; i >= 0; i--) host.put(d[8*i+:8], a1);
    host.stop();
  endtask
  task automatic rd4();
    for (int i = 3; i >= 0; i--) begin
      host.get(i == 0, b);
      v = {v[23:0], b};
    end
    host.stop();
  endtask
  task automatic pend();
    alert_event <= 1'b1;
    @(posedge pclk);
    alert_event <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rdc("cfg", tgt_pkg::CFG_ADDR, 32'hd0000032);
    rdc("hole", 32'h0001d13c, 32'h0);
    `CHK("pslverr", 1'b1, err);
    wr(tgt_pkg::CFG_ADDR, 32'hd000007d);
    rdc("cfg locked", tgt_pkg::CFG_ADDR, 32'hd000007e);
    wr(tgt_pkg::CFG_ADDR, 32'hd1000031);
    rdc("cfg unlocked", tgt_pkg::CFG_ADDR, 32'hd1000031);
    wr(tgt_pkg::CFG_ADDR, 32'hd1000032);
    $display("regs done");
  endtask
  task automatic t_write();
    n = wr_n;
    adr({SA, 1'b0});
    `CHK("ack", 1'b1, a1);
    wr4(32'h12345678);
    `CHK("wr count", n + 1, wr_n);
    `CHK("wr addr", WA, wr_a);
    `CHK("wr data", 32'h12345678, wr_d);
    `CHK("irq masked", 1'b0, irq);
    wr(tgt_pkg::MASK_ADDR, 32'h1);
    @(posedge pclk);
    `CHK("irq", 1'b1, irq);
    wr(tgt_pkg::STAT_ADDR, 32'h1);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq);
    $display("write done");
  endtask
  task automatic t_read();
    n = rd_n;
    adr({SA, 1'b1});
    `CHK("ack", 1'b1, a1);
    rd4();
    `CHK("rd data", RD, v);
    `CHK("rd count", n + 1, rd_n);
    `CHK("rd addr", RA, rd_a);
    $display("read done");
  endtask
  task automatic t_deny();
    wr(tgt_pkg::CFG_ADDR, 32'h10000032);
    n = wr_n;
    m = rd_n;
    adr({SA, 1'b0});
    wr4(32'hcafe0001);
    adr({SA, 1'b1});
    rd4();
    `CHK("rd zero", 32'h0, v);
    `CHK("wr blocked", n, wr_n);
    `CHK("rd blocked", m, rd_n);
    apb(1'b0, tgt_pkg::STAT_ADDR, '0, v);
    `CHK("refused", 1'b1, v[3]);
    wr(tgt_pkg::CFG_ADDR, 32'hc0000032);
    adr({SA, 1'b0});
    host.stop();
    `CHK("target off", 1'b0, a1);
    wr(tgt_pkg::CFG_ADDR, 32'hd0000032);
    adr(8'h00);
    host.stop();
    `CHK("general call", 1'b0, a1);
    $display("deny done");
  endtask
  task automatic t_alert();
    wr(tgt_pkg::CFG_ADDR, 32'hf0000032);
    pend();
    rdc("pending", tgt_pkg::ALERT_ADDR, 32'h1);
    adr({tgt_pkg::ALERT_RSP, 1'b1});
    `CHK("alert ack", 1'b1, a1);
    host.get(1'b1, b);
    host.stop();
    `CHK("alert byte", {SA, 1'b0}, b);
    rdc("pending cleared", tgt_pkg::ALERT_ADDR, 32'h0);
    wr(tgt_pkg::CFG_ADDR, 32'hd0000032);
    wr(tgt_pkg::ALERT_ADDR, 32'h1);
    adr({tgt_pkg::ALERT_RSP, 1'b1});
    host.stop();
    `CHK("alert off", 1'b0, a1);
    rdc("pending kept", tgt_pkg::ALERT_ADDR, 32'h1);
    wr(tgt_pkg::CFG_ADDR, 32'hd100000c);
    adr({tgt_pkg::ALERT_RSP, 1'b0});
    host.stop();
    `CHK("own address", 1'b1, a1);
    wr(tgt_pkg::CFG_ADDR, 32'hf100000c);
    pend();
    m = rd_n;
    adr({tgt_pkg::ALERT_RSP, 1'b1});
    host.get(1'b1, b);
    host.stop();
    `CHK("alert first", 8'h18, b);
    `CHK("alert no read", m, rd_n);
    $display("alert done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_regs();
    t_write();
    t_read();
    t_deny();
    t_alert();
    test_done();
  end
endmodule
